// ==== rtl/ep_event_flags.v ====
`timescale 1ns/1ps
`include "ep_status_regs.vh"

// =====================================================================
// one endpoint's sticky event flags
module ep_event_flags (
	input  wire       clk,         // system clock
	input  wire       arst_n,      // async reset, active low
	input  wire [6:0] set_pulse,   // hardware event pulses
	input  wire [6:0] clear_pulse, // software write-one-to-clear
	output reg  [6:0] flags_reg    // flag state
);
	wire [6:0] flags_next;

	assign flags_next = ((flags_reg & ~clear_pulse) | set_pulse) & `FLAG_IMPLEMENTED_MASK;

	always @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			flags_reg <= `EVENT_FLAGS_RESET;
		else
			flags_reg <= flags_next;
	end
endmodule

// ==== rtl/ep_status_len.v ====
`timescale 1ns/1ps
`include "ep_status_regs.vh"
// Notes on behaviour
// - each event flag is set by hardware only and cleared by writing one to its bit.
// - there is one OUT event flag register per endpoint 0 to 3 at a stride of 0x20 from 0xb08.
// - the back-to-back setup flag, bit 6, sets on a control endpoint when more than three setup packets arrive in a row.
// - the receive overrun flag, bit 4, sets when an OUT token finds too little receive FIFO room.
// - on receive overrun the OUT data is dropped and a NAK is returned to the host.
// - the setup-phase-done flag, bit 3, sets on a control endpoint when an IN or OUT token follows a setup token.
// - the endpoint-disabled flag, bit 1, sets when the endpoint is disabled on software request.
// - the transfer-done flag, bit 0, sets when all programmed OUT transactions are done.
// - the IN length register holds a two-bit packet count in bits 20 to 19, set by software first.
// - the IN packet count drops by one after each data packet sent on the bus.
// - the IN length register holds a seven-bit byte count in bits 6 to 0, set by software first.
// - the IN byte count drops by the packet size at each successful transmit FIFO push.
// - the OUT length register holds a packet count at bit 19 and byte count in 6 to 0, zero at reset.

module ep_status_len (
	input  wire        clk,             // 125 MHz system clock
	input  wire        arst_n,          // async reset, active low
	input  wire [11:0] reg_addr,        // register byte address
	input  wire        reg_wr,          // write strobe, one cycle
	input  wire        reg_rd,          // read strobe, one cycle
	input  wire [31:0] reg_wdata,       // write data
	output reg  [31:0] reg_rdata,       // read data, valid the cycle after reg_rd
	input  wire [3:0]  setup_rx,        // setup packet received, per endpoint
	input  wire [3:0]  data_token_rx,   // IN or OUT token received, per endpoint
	input  wire [3:0]  out_token_rx,    // OUT token received, per endpoint
	input  wire [3:0]  rx_fifo_room_ok, // receive FIFO can hold the packet, per endpoint
	input  wire [3:0]  ep_disabled,     // endpoint disabled on request, pulse
	input  wire [3:0]  out_xfer_done,   // all OUT transactions finished, pulse
	input  wire [3:0]  ep_is_control,   // endpoint is a control endpoint
	input  wire        in0_pkt_sent,    // ep0 IN data packet sent, pulse
	input  wire        in0_fifo_push,   // ep0 transmit FIFO packet pushed, pulse
	input  wire [6:0]  in0_push_bytes,  // size of pushed packet
	input  wire        out0_pkt_rcvd,   // ep0 OUT data packet received, pulse
	input  wire        out0_fifo_pop,   // ep0 receive FIFO packet read out, pulse
	input  wire [6:0]  out0_pop_bytes,  // size of popped packet
	output reg  [3:0]  out_drop_nak,    // drop packet and answer NAK, per endpoint
	output reg  [1:0]  in0_packet_count,  // ep0 IN packet count
	output reg  [6:0]  in0_byte_count,    // ep0 IN byte count
	output reg         out0_packet_count, // ep0 OUT packet count
	output reg  [6:0]  out0_byte_count    // ep0 OUT byte count
);
	// =====================================================================
	// address decode
	wire        sel_in0  = (reg_addr == `IN_EP0_TRANSFER_SIZE_OFS);
	wire        sel_out0 = (reg_addr == `OUT_EP0_TRANSFER_SIZE_OFS);
	wire        wr_in0   = reg_wr && sel_in0;
	wire        wr_out0  = reg_wr && sel_out0;
	wire [3:0]  sel_flags;
	wire [3:0]  overrun_hit;
	wire [6:0]  flags [0:3];

	// =====================================================================
	// per-endpoint flag logic
	genvar e;
	generate
		for (e = 0; e < `ENDPOINT_COUNT; e = e + 1) begin : g_ep
			// the stride product is integer wide; only the low 12 address bits decode
			localparam [31:0] ofs_full = `OUT_EP_EVENT_FLAGS_OFS + e * `OUT_EP_STRIDE;

			wire [11:0] ofs = ofs_full[11:0];
			wire        ctl = ep_is_control[e];
			wire        hit_wr;
			wire        b2b;
			wire        stp_done;
			wire [6:0]  set_v;
			wire [6:0]  clr_v;
			reg  [1:0]  setup_run_reg;
			reg  [1:0]  setup_run_next;

			assign sel_flags[e] = (reg_addr == ofs);
			assign hit_wr       = reg_wr && sel_flags[e];

			assign overrun_hit[e] = out_token_rx[e] && !rx_fifo_room_ok[e];

			assign b2b = ctl && setup_rx[e] && (setup_run_reg == `SETUP_RUN_LIMIT);

			assign stp_done = ctl && data_token_rx[e] && (setup_run_reg != 2'h0);

			assign set_v = {b2b, 1'b0, overrun_hit[e], stp_done, 1'b0, ep_disabled[e], out_xfer_done[e]};

			assign clr_v = hit_wr ? reg_wdata[6:0] : 7'h00;

			// any data token ends the run; the count saturates so a long
			// burst of setups keeps re-setting the flag instead of wrapping
			always @* begin
				setup_run_next = setup_run_reg;
				if (data_token_rx[e])
					setup_run_next = 2'h0;
				else if (setup_rx[e] && (setup_run_reg != `SETUP_RUN_LIMIT))
					setup_run_next = setup_run_reg + 2'h1;
			end

			always @(posedge clk or negedge arst_n) begin
				if (!arst_n)
					setup_run_reg <= 2'h0;
				else
					setup_run_reg <= setup_run_next;
			end

			ep_event_flags u_flags (
				.clk         (clk),
				.arst_n      (arst_n),
				.set_pulse   (set_v),
				.clear_pulse (clr_v),
				.flags_reg   (flags[e])
			);
		end
	endgenerate

	// =====================================================================
	// overrun answer
	// drop and nak
	// registered so the packet engine sees one clean pulse per refused token
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			out_drop_nak <= 4'h0;
		else
			out_drop_nak <= overrun_hit;
	end

	// =====================================================================
	// ep0 IN length: next value
	reg [1:0]  in0_packet_count_next;
	reg [6:0]  in0_byte_count_next;
	reg        out0_packet_count_next;
	reg [6:0]  out0_byte_count_next;

	// a write beats a same-cycle decrement, so a freshly programmed count is never lost
	always @* begin
		in0_packet_count_next = in0_packet_count;
		in0_byte_count_next   = in0_byte_count;
		if (wr_in0) begin
			in0_packet_count_next = reg_wdata[`IN_PACKET_COUNT_HI:`IN_PACKET_COUNT_LO];
			in0_byte_count_next   = reg_wdata[`BYTE_COUNT_HI:`BYTE_COUNT_LO];
		end else begin
			if (in0_pkt_sent && (in0_packet_count != 2'h0))
				in0_packet_count_next = in0_packet_count - 2'h1;
			// bytes per push
			// floors at zero: an oversized push would otherwise wrap to a huge count
			if (in0_fifo_push && (in0_push_bytes > in0_byte_count))
				in0_byte_count_next = 7'h00;
			else if (in0_fifo_push)
				in0_byte_count_next = in0_byte_count - in0_push_bytes;
		end
	end

	// =====================================================================
	// ep0 OUT length: next value
	always @* begin
		out0_packet_count_next = out0_packet_count;
		out0_byte_count_next   = out0_byte_count;
		if (wr_out0) begin
			out0_packet_count_next = reg_wdata[`OUT_PACKET_COUNT_BIT];
			out0_byte_count_next   = reg_wdata[`BYTE_COUNT_HI:`BYTE_COUNT_LO];
		end else begin
			// one-bit count: a received packet empties it
			if (out0_pkt_rcvd)
				out0_packet_count_next = 1'b0;
			// same floor as the IN side
			if (out0_fifo_pop && (out0_pop_bytes > out0_byte_count))
				out0_byte_count_next = 7'h00;
			else if (out0_fifo_pop)
				out0_byte_count_next = out0_byte_count - out0_pop_bytes;
		end
	end

	// =====================================================================
	// ep0 length registers
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			in0_packet_count  <= 2'h0;
			in0_byte_count    <= 7'h00;
			out0_packet_count <= 1'b0;
			out0_byte_count   <= 7'h00;
		end else begin
			in0_packet_count  <= in0_packet_count_next;
			in0_byte_count    <= in0_byte_count_next;
			out0_packet_count <= out0_packet_count_next;
			out0_byte_count   <= out0_byte_count_next;
		end
	end

	// =====================================================================
	// read mux; reserved bits and unmapped addresses read zero
	reg [31:0] rdata_next;
	integer    i;

	always @* begin
		rdata_next = 32'h00000000;
		if (sel_in0)
			rdata_next = {11'h0, in0_packet_count, 12'h0, in0_byte_count};
		if (sel_out0)
			rdata_next = {12'h0, out0_packet_count, 12'h0, out0_byte_count};
		for (i = 0; i < `ENDPOINT_COUNT; i = i + 1)
			if (sel_flags[i])
				rdata_next = {25'h0, flags[i]};
	end

	// =====================================================================
	// read data register
	// captured only on a read strobe, so the answer stands until the next read
	always @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			reg_rdata <= 32'h00000000;
		else if (reg_rd)
			reg_rdata <= rdata_next;
	end
endmodule

// ==== rtl/ep_status_regs.vh ====
`ifndef EP_STATUS_REGS_VH
`define EP_STATUS_REGS_VH

// =====================================================================
// register offsets (byte addresses)
`define IN_EP0_TRANSFER_SIZE_OFS     12'h910
`define OUT_EP_EVENT_FLAGS_OFS       12'hb08
`define OUT_EP_STRIDE                12'h020
`define OUT_EP0_TRANSFER_SIZE_OFS    12'hb10
`define ENDPOINT_COUNT               4

// =====================================================================
// event flag bit positions
`define FLAG_TRANSFER_DONE_BIT       0
`define FLAG_ENDPOINT_DISABLED_BIT   1
`define FLAG_SETUP_PHASE_DONE_BIT    3
`define FLAG_RECEIVE_OVERRUN_BIT     4
`define FLAG_BACK_TO_BACK_SETUP_BIT  6
`define FLAG_IMPLEMENTED_MASK        7'h5b

// =====================================================================
// length register fields
`define IN_PACKET_COUNT_HI           20
`define IN_PACKET_COUNT_LO           19
`define OUT_PACKET_COUNT_BIT         19
`define BYTE_COUNT_HI                6
`define BYTE_COUNT_LO                0

// =====================================================================
// reset values and thresholds
`define EVENT_FLAGS_RESET            7'h00
`define TRANSFER_SIZE_RESET          32'h00000000
`define SETUP_RUN_LIMIT              2'h3

`endif

// ==== tb/ep_status_len_asserts.sv ====
`timescale 1ns/1ps
// =====
// port checks
module ep_status_len_asserts (
	input wire        clk,               // clock
	input wire        arst_n,            // reset
	input wire [11:0] reg_addr,          // address
	input wire        reg_wr,            // write
	input wire        reg_rd,            // read
	input wire [31:0] reg_wdata,         // wdata
	input wire [31:0] reg_rdata,         // rdata
	input wire [3:0]  out_token_rx,      // out token
	input wire [3:0]  rx_fifo_room_ok,   // room
	input wire        in0_pkt_sent,      // in sent
	input wire        out0_pkt_rcvd,     // out rcvd
	input wire [3:0]  out_drop_nak,      // nak
	input wire [1:0]  in0_packet_count,  // in pc
	input wire [6:0]  in0_byte_count,    // in bytes
	input wire        out0_packet_count, // out pc
	input wire [6:0]  out0_byte_count    // out bytes
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	wire w_in = reg_wr && reg_addr == 12'h910;
	wire w_out = reg_wr && reg_addr == 12'hb10;
	nak_match_a: assert property (out_drop_nak == $past(out_token_rx & ~rx_fifo_room_ok))
		else $error("nak mismatch");
	in_pc_dec_a: assert property (in0_pkt_sent && !w_in && in0_packet_count != 2'h0
		|=> in0_packet_count == $past(in0_packet_count) - 2'h1) else $error("in count not decremented");
	in_pc_hold_a: assert property (!in0_pkt_sent && !w_in |=> $stable(in0_packet_count))
		else $error("in count moved");
	in_write_a: assert property (w_in |=> in0_packet_count == $past(reg_wdata[20:19])
		&& in0_byte_count == $past(reg_wdata[6:0])) else $error("in length write lost");
	in_read_a: assert property (reg_rd && reg_addr == 12'h910
		|=> reg_rdata == {11'h0, $past(in0_packet_count), 12'h0, $past(in0_byte_count)}) else $error("in read bad");
	out_clr_a: assert property (out0_pkt_rcvd && !w_out |=> !out0_packet_count)
		else $error("out count kept");
	out_read_a: assert property (reg_rd && reg_addr == 12'hb10
		|=> reg_rdata == {12'h0, $past(out0_packet_count), 12'h0, $past(out0_byte_count)}) else $error("out read bad");
	rd_hold_a: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("rdata moved");
	cover property (out_drop_nak != 4'h0);
	cover property (in0_pkt_sent && in0_packet_count != 2'h0);
	cover property (out0_pkt_rcvd && out0_packet_count);
endmodule
bind ep_status_len ep_status_len_asserts chk_i (.*);

// ==== tb/ep_status_len_bench.sv ====
`timescale 1ns/1ps
// =====
// bench
module ep_status_len_bench;
	logic clk, arst_n, reg_wr, reg_rd, go, in0_fifo_push, out0_fifo_pop, out0_packet_count, in0_pkt_sent, out0_pkt_rcvd;
	logic [11:0] reg_addr, a;
	logic [31:0] reg_wdata, reg_rdata, v;
	logic [3:0] setup_rx, data_token_rx, out_token_rx, rx_fifo_room_ok, ep_disabled, out_xfer_done, ep_is_control;
	logic [3:0] out_drop_nak;
	logic [6:0] in0_push_bytes, out0_pop_bytes, in0_byte_count, out0_byte_count, b, c;
	logic [1:0] in0_packet_count, ep;
	logic [2:0] kind;
	logic ovr;
	int err_total, tests_run, e, n;
	ep_status_len DUT (.*);
	usb_host_model host (.*);
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task results;
		if (err_total == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task wr(input logic [11:0] ad, input logic [31:0] d);
		@(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, ad, d};
		@(posedge clk) reg_wr <= 1'b0;
	endtask
	task rd(input logic [11:0] ad, input logic [31:0] x);
		@(posedge clk) {reg_rd, reg_addr} <= {1'b1, ad};
		@(posedge clk) reg_rd <= 1'b0;
		#1 chk(reg_rdata, x);
	endtask
	task hs(input logic [2:0] k, input logic [1:0] p);
		@(posedge clk) {go, kind, ep} <= {1'b1, k, p};
		@(posedge clk) go <= 1'b0;
		@(posedge clk);
	endtask
	initial begin
		#200000 err_total++;
		results();
	end
	initial begin
		{reg_wr, reg_rd, go, in0_fifo_push, out0_fifo_pop, kind, ep, reg_addr, reg_wdata} = 0;
		{ep_disabled, out_xfer_done, ep_is_control, in0_push_bytes, out0_pop_bytes, rx_fifo_room_ok} = 0;
		arst_n = 0;
		v = $urandom(32'h52bd);
		repeat (10) @(posedge clk);
		arst_n <= 1'b1;
		rd(12'h910, 0);
		rd(12'hb10, 0);
		wr(12'ha00, '1);
		rd(12'ha00, 0);
		for (e = 0; e < 4; e++) begin
			a = 12'hb08 + {5'h0, e[1:0], 5'h0};
			n = 3 + $urandom % 2;
			ovr = $urandom;
			@(posedge clk) ep_is_control <= $urandom;
			rx_fifo_room_ok <= ovr ? ~(4'h1 << e[1:0]) : 4'hf;
			rd(a, 0);
			repeat (n) hs(0, e[1:0]);
			hs(1, e[1:0]);
			hs(2, e[1:0]);
			@(posedge clk) {ep_disabled, out_xfer_done} <= {2{4'h1 << e[1:0]}};
			@(posedge clk) {ep_disabled, out_xfer_done} <= 8'h00;
			v = {25'h0, ep_is_control[e] && n > 3, 1'b0, ovr, ep_is_control[e], 1'b0, 2'b11};
			rd(a, v);
			wr(a, 32'h1);
			rd(a, v & ~32'h1);
			wr(a, 32'h0000005b);
			rd(a, 0);
		end
		repeat (8) begin
			b = $urandom;
			c = $urandom % (b + 1);
			v = {11'h0, 2'($urandom), 12'h0, b};
			wr(12'h910, v);
			rd(12'h910, v);
			hs(3, 0);
			@(posedge clk) {in0_fifo_push, in0_push_bytes} <= {1'b1, c};
			@(posedge clk) in0_fifo_push <= 1'b0;
			#1 chk(in0_byte_count, b - c);
			chk(in0_packet_count, v[20:19] - (v[20:19] != 2'h0));
			wr(12'hb10, {12'h0, 1'b1, 12'h0, b});
			hs(4, 0);
			@(posedge clk) {out0_fifo_pop, out0_pop_bytes} <= {1'b1, c};
			@(posedge clk) out0_fifo_pop <= 1'b0;
			rd(12'hb10, {25'h0, 7'(b - c)});
		end
		results();
	end
endmodule

// ==== tb/usb_host_model.sv ====
`timescale 1ns/1ps
// =====
// host token and packet pulses
module usb_host_model (
	input wire       clk,           // clock
	input wire       go,            // request
	input wire [2:0] kind,          // 0 setup 1 data 2 out 3 in sent 4 out rcvd
	input wire [1:0] ep,            // endpoint
	output reg [3:0] setup_rx,      // setup
	output reg [3:0] data_token_rx, // in or out token
	output reg [3:0] out_token_rx,  // out token
	output reg       in0_pkt_sent,  // in packet acked
	output reg       out0_pkt_rcvd  // out packet taken
);
	initial {setup_rx, data_token_rx, out_token_rx, in0_pkt_sent, out0_pkt_rcvd} = 14'h0;
	// one-cycle pulses, as on the bus each token is a single event
	always @(posedge clk) begin
		setup_rx <= (go && kind == 3'h0) ? 4'h1 << ep : 4'h0;
		data_token_rx <= (go && (kind == 3'h1 || kind == 3'h2)) ? 4'h1 << ep : 4'h0;
		out_token_rx <= (go && kind == 3'h2) ? 4'h1 << ep : 4'h0;
		in0_pkt_sent <= go && kind == 3'h3;
		out0_pkt_rcvd <= go && kind == 3'h4;
	end
endmodule
